// [rtl/ulm_pkg.sv]
// Package: offsets, field positions, reset values and carriers of the line and modem status block
`default_nettype none

package ulm_pkg;

  // ==========================================================================
  // Register port
  // ==========================================================================
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] OFS_RX_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_LINE_STATE = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STATE = 3'h6;
  localparam logic [ADDR_W-1:0] OFS_BYTE_A = 3'h7;

  // ==========================================================================
  // Field positions
  // ==========================================================================
  localparam int LINE_DR_BIT = 0;
  localparam int LINE_OE_BIT = 1;
  localparam int LINE_PE_BIT = 2;
  localparam int LINE_FE_BIT = 3;
  localparam int CHG_CTS_BIT = 0;
  localparam int CHG_DSR_BIT = 1;
  localparam int CHG_RING_BIT = 2;
  localparam int CHG_CARRIER_BIT = 3;
  localparam int MODEM_CTS_BIT = 4;
  localparam int MODEM_DSR_BIT = 5;
  localparam int MODEM_RING_BIT = 6;
  localparam int MODEM_CARRIER_BIT = 7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [DATA_W-1:0] RST_LINE_STATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_MODEM_STATE = 8'h00;
  localparam logic [DATA_W-1:0] RST_BYTE_A = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE = 8'h00;

  // Modem inputs have no pins: tied to their inactive (high) level
  // Order: carrier_in_n, ring_in_n, set_ready_in_n, clear_to_tx_in_n
  localparam logic [3:0] MODEM_IN_N_TIED = 4'hF;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] data;
    logic parity_en;
    logic parity_bit;
    logic stop_bit;
    logic brk;
  } ulm_rx_char_type;

  typedef struct packed {
    logic brk;
    logic fe;
    logic pe;
    logic [7:0] data;
  } ulm_entry_type;

  typedef struct packed {
    logic [2:0] unused;
    logic loop;
    logic general_out_b;
    logic general_out_a;
    logic request_tx_ctl;
    logic terminal_ready;
  } ulm_modem_ctl_type;

  localparam int ENTRY_W = $bits(ulm_entry_type);

endpackage

`default_nettype wire

// [rtl/ulm_fifo_mem.sv]
// Receive storage: one write port, registered read with write bypass
`timescale 1ns/10ps
`default_nettype none

module ulm_fifo_mem #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Write port
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [WIDTH-1:0] i_wdata,
  // Read port
  input wire logic [AW-1:0] i_raddr,
  output logic [WIDTH-1:0] o_rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ==========================================================================
  // Storage
  // ==========================================================================
  always_ff @(posedge i_clk)
  begin
    if (i_we)
    begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  // Bypass so a word written into the next head shows without a stale cycle
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= '0;
    end
    else if (i_we && (i_waddr == i_raddr))
    begin
      o_rdata <= i_wdata;
    end
    else
    begin
      o_rdata <= mem_q[i_raddr];
    end
  end

endmodule // ulm_fifo_mem

`default_nettype wire

// [rtl/ulm_line_modem_status.sv]
// Line status flags, modem line state, byte_a byte and receive FIFO of a serial port
//
// Behaviour
// - Stop bit low sets framing flag; read clears
// - FIFO errors reported when character reaches head
// - After framing error, receiver resyncs on low
// - Wrong even/odd parity sets parity flag
// - Unread buffer overwritten sets overrun at once
// - FIFO overrun only when full; character dropped
// - Data ready until all received data read
// - Bit 7 inverse carrier, loopback general_out_b
// - Bit 6 inverse ring, loopback general_out_a
// - Bit 5 inverse set-ready, loopback terminal-ready
// - Bit 4 inverse clear-to-send, loopback request
// - Modem control bit 4 selects loopback
// - Carrier change sets bit 3
// - Ring input low-to-high sets bit 2
// - Set-ready change sets bit 1; read clears
// - Clear-to-send change sets bit 0; read clears
// - Any change bit raises modem interrupt
// - Modem lines have no pins; loopback only
// - Byte_a byte read/write, reset zero
`timescale 1ns/10ps
`default_nettype none

module ulm_line_modem_status #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Register port
  input wire logic [ulm_pkg::ADDR_W-1:0] i_addr,
  input wire logic [ulm_pkg::DATA_W-1:0] i_wr_data,
  input wire logic i_wr_stb,
  input wire logic i_rd_stb,
  output logic [ulm_pkg::DATA_W-1:0] o_rd_data,
  // Receiver side
  input wire logic i_rx_valid,
  input wire ulm_pkg::ulm_rx_char_type i_rx_char,
  output logic o_rx_resync,
  // Line and modem control settings
  input wire logic i_fifo_mode,
  input wire logic i_even_parity,
  input wire ulm_pkg::ulm_modem_ctl_type i_modem_ctl,
  // Status
  output logic o_data_ready,
  output logic o_modem_irq
);

  localparam int AW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int CW = AW + 1;
  localparam logic [CW-1:0] FULL_COUNT = CW'(FIFO_DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(FIFO_DEPTH - 1);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == LAST_PTR) ? '0 : AW'(p + 1'b1);
  endfunction

  function automatic logic parity_bad(input ulm_pkg::ulm_rx_char_type c, input logic even);
    parity_bad = c.parity_en && ((^c.data ^ c.parity_bit) ^ ~even);
  endfunction

  // ==========================================================================
  // Decode
  // ==========================================================================
  logic rd_rx;
  logic rd_line;
  logic rd_modem;
  logic wr_pad;
  assign rd_rx = i_rd_stb && (i_addr == ulm_pkg::OFS_RX_DATA);
  assign rd_line = i_rd_stb && (i_addr == ulm_pkg::OFS_LINE_STATE);
  assign rd_modem = i_rd_stb && (i_addr == ulm_pkg::OFS_MODEM_STATE);
  assign wr_pad = i_wr_stb && (i_addr == ulm_pkg::OFS_BYTE_A);

  ulm_pkg::ulm_entry_type entry_in;
  always_comb
  begin
    entry_in.data = i_rx_char.data;
    entry_in.pe = parity_bad(i_rx_char, i_even_parity);
    entry_in.fe = ~i_rx_char.stop_bit;
    entry_in.brk = i_rx_char.brk;
  end

  // ==========================================================================
  // Receive FIFO
  // ==========================================================================
  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic fifo_full;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_overrun;
  logic head_fresh_q;
  ulm_pkg::ulm_entry_type head;

  assign fifo_full = (count_q == FULL_COUNT);
  assign fifo_pop = rd_rx && i_fifo_mode && (count_q != '0);
  // Character in the shift register is lost, not stored
  assign fifo_push = i_rx_valid && i_fifo_mode && (!fifo_full || fifo_pop);
  assign fifo_overrun = i_rx_valid && i_fifo_mode && fifo_full && !fifo_pop;
  assign rd_ptr_d = fifo_pop ? ptr_inc(rd_ptr_q) : rd_ptr_q;

  always_comb
  begin
    count_d = count_q;
    if (fifo_push && !fifo_pop)
    begin
      count_d = CW'(count_q + 1'b1);
    end
    else if (fifo_pop && !fifo_push)
    begin
      count_d = CW'(count_q - 1'b1);
    end
  end

  // Switching mode leaves stale entries; software flushes by reading them out
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      count_q <= '0;
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end
    else
    begin
      count_q <= count_d;
      rd_ptr_q <= rd_ptr_d;
      if (fifo_push)
      begin
        wr_ptr_q <= ptr_inc(wr_ptr_q);
      end
    end
  end

  // A new head appears after a push into empty or a pop with more behind
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      head_fresh_q <= 1'b0;
    end
    else
    begin
      head_fresh_q <= i_fifo_mode && (count_d != '0) && ((count_q == '0) || fifo_pop);
    end
  end

  ulm_fifo_mem #(
    .WIDTH(ulm_pkg::ENTRY_W),
    .DEPTH(FIFO_DEPTH),
    .AW(AW)
  ) u_mem (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_we(fifo_push),
    .i_waddr(wr_ptr_q),
    .i_wdata(entry_in),
    .i_raddr(rd_ptr_d),
    .o_rdata(head)
  );

  // ==========================================================================
  // Single holding buffer outside FIFO mode
  // ==========================================================================
  ulm_pkg::ulm_entry_type hold_q;
  logic hold_full_q;
  logic hold_full_d;
  logic hold_push;
  logic hold_pop;
  logic hold_overrun;

  assign hold_push = i_rx_valid && !i_fifo_mode;
  assign hold_pop = rd_rx && !i_fifo_mode;
  assign hold_overrun = hold_push && hold_full_q && !hold_pop;
  assign hold_full_d = hold_push ? 1'b1 : (hold_pop ? 1'b0 : hold_full_q);

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      hold_q <= '0;
      hold_full_q <= 1'b0;
    end
    else
    begin
      hold_full_q <= hold_full_d;
      if (hold_push)
      begin
        hold_q <= entry_in;
      end
    end
  end

  // ==========================================================================
  // Line state flags
  // ==========================================================================
  logic fe_q;
  logic pe_q;
  logic oe_q;
  logic fe_set;
  logic pe_set;
  logic oe_set;
  logic dr_d;

  // FIFO mode reports errors with the head, not on arrival
  assign fe_set = i_fifo_mode ? (head_fresh_q && head.fe) : (hold_push && entry_in.fe);
  assign pe_set = i_fifo_mode ? (head_fresh_q && head.pe) : (hold_push && entry_in.pe);
  assign oe_set = hold_overrun || fifo_overrun;
  assign dr_d = i_fifo_mode ? (count_d != '0) : hold_full_d;

  // Set wins over the clearing read so no event slips through
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      fe_q <= ulm_pkg::RST_LINE_STATE[ulm_pkg::LINE_FE_BIT];
      pe_q <= ulm_pkg::RST_LINE_STATE[ulm_pkg::LINE_PE_BIT];
      oe_q <= ulm_pkg::RST_LINE_STATE[ulm_pkg::LINE_OE_BIT];
      o_data_ready <= ulm_pkg::RST_LINE_STATE[ulm_pkg::LINE_DR_BIT];
    end
    else
    begin
      fe_q <= fe_set || (fe_q && !rd_line);
      pe_q <= pe_set || (pe_q && !rd_line);
      oe_q <= oe_set || (oe_q && !rd_line);
      o_data_ready <= dr_d;
    end
  end

  // Receiver restarts on the low level it saw as a stop bit
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rx_resync <= 1'b0;
    end
    else
    begin
      o_rx_resync <= i_rx_valid && entry_in.fe;
    end
  end

  // ==========================================================================
  // Modem line state
  // ==========================================================================
  logic [3:0] lines_q;
  logic [3:0] lines_d;
  logic [3:0] delta_q;
  logic [3:0] delta_set;
  logic [3:0] delta_d;

  // No modem pins exist, so outside loopback the lines read inactive
  always_comb
  begin
    if (i_modem_ctl.loop)
    begin
      lines_d = {i_modem_ctl.general_out_b,
                 i_modem_ctl.general_out_a,
                 i_modem_ctl.terminal_ready,
                 i_modem_ctl.request_tx_ctl};
    end
    else
    begin
      lines_d = ~ulm_pkg::MODEM_IN_N_TIED;
    end
  end

  always_comb
  begin
    delta_set = '0;
    delta_set[3] = lines_d[3] != lines_q[3];
    delta_set[2] = lines_q[2] && !lines_d[2];
    delta_set[1] = lines_d[1] != lines_q[1];
    delta_set[0] = lines_d[0] != lines_q[0];
    delta_d = delta_set | (delta_q & {4{!rd_modem}});
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      lines_q <= ulm_pkg::RST_MODEM_STATE[ulm_pkg::MODEM_CARRIER_BIT:ulm_pkg::MODEM_CTS_BIT];
      delta_q <= ulm_pkg::RST_MODEM_STATE[ulm_pkg::CHG_CARRIER_BIT:ulm_pkg::CHG_CTS_BIT];
      o_modem_irq <= 1'b0;
    end
    else
    begin
      lines_q <= lines_d;
      delta_q <= delta_d;
      o_modem_irq <= |delta_d;
    end
  end

  // ==========================================================================
  // Byte_a byte and read data
  // ==========================================================================
  logic [ulm_pkg::DATA_W-1:0] byte_a_q;
  logic [ulm_pkg::DATA_W-1:0] line_val;
  logic [ulm_pkg::DATA_W-1:0] rd_d;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      byte_a_q <= ulm_pkg::RST_BYTE_A;
    end
    else if (wr_pad)
    begin
      byte_a_q <= i_wr_data;
    end
  end

  always_comb
  begin
    line_val = '0;
    line_val[ulm_pkg::LINE_DR_BIT] = o_data_ready;
    line_val[ulm_pkg::LINE_OE_BIT] = oe_q;
    line_val[ulm_pkg::LINE_PE_BIT] = pe_q;
    line_val[ulm_pkg::LINE_FE_BIT] = fe_q;
    rd_d = ulm_pkg::RD_IDLE;
    if (i_rd_stb)
    begin
      case (i_addr)
        ulm_pkg::OFS_RX_DATA: rd_d = i_fifo_mode ? head.data : hold_q.data;
        ulm_pkg::OFS_LINE_STATE: rd_d = line_val;
        ulm_pkg::OFS_MODEM_STATE: rd_d = {lines_q, delta_q};
        ulm_pkg::OFS_BYTE_A: rd_d = byte_a_q;
        default: rd_d = ulm_pkg::RD_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rd_data <= ulm_pkg::RD_IDLE;
    end
    else
    begin
      o_rd_data <= rd_d;
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_fe_set;
    hold_push && !i_rx_char.stop_bit |=> fe_q ##1 (fe_q || $past(rd_line));
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing flag not set");

  property p_fe_clr;
    rd_line && !fe_set |=> !fe_q && (o_rd_data[ulm_pkg::LINE_FE_BIT] == $past(fe_q));
  endproperty
  a_fe_clr: assert property (p_fe_clr) else $error("framing flag not cleared by read");

  property p_fifo_head_err;
    (i_fifo_mode && i_rx_valid && count_q == '0 && !i_rx_char.stop_bit)
      ##1 (i_fifo_mode && !rd_line) |=> fe_q;
  endproperty
  a_fifo_head_err: assert property (p_fifo_head_err) else $error("head error not shown");

  property p_resync;
    i_rx_valid && !i_rx_char.stop_bit |=> o_rx_resync;
  endproperty
  a_resync: assert property (p_resync) else $error("no resync after framing error");

  property p_parity;
    hold_push && i_rx_char.parity_en && ((^i_rx_char.data ^ i_rx_char.parity_bit) == i_even_parity)
      |=> pe_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag not set");

  property p_oe_hold;
    hold_push && hold_full_q && !rd_rx |=> oe_q && hold_full_q;
  endproperty
  a_oe_hold: assert property (p_oe_hold) else $error("overrun not flagged");

  property p_oe_fifo;
    i_fifo_mode && i_rx_valid && fifo_full && !rd_rx |=> oe_q && count_q == FULL_COUNT
      && wr_ptr_q == $past(wr_ptr_q);
  endproperty
  a_oe_fifo: assert property (p_oe_fifo) else $error("full FIFO took a character");

  property p_dr;
    $stable(i_fifo_mode) && i_fifo_mode |-> o_data_ready == (count_q != '0);
  endproperty
  a_dr: assert property (p_dr) else $error("data ready disagrees with FIFO");

  property p_loop_lines;
    i_modem_ctl.loop |=> o_modem_irq == |delta_q ##0 lines_q[3] == $past(i_modem_ctl.general_out_b)
      && lines_q[0] == $past(i_modem_ctl.request_tx_ctl);
  endproperty
  a_loop_lines: assert property (p_loop_lines) else $error("loopback lines wrong");

  property p_no_loop;
    !i_modem_ctl.loop |=> lines_q == ~ulm_pkg::MODEM_IN_N_TIED;
  endproperty
  a_no_loop: assert property (p_no_loop) else $error("lines not idle outside loopback");

  property p_ring_edge;
    (i_modem_ctl.loop && i_modem_ctl.general_out_a) ##1 (i_modem_ctl.loop
      && !i_modem_ctl.general_out_a) |=> delta_q[ulm_pkg::CHG_RING_BIT] && o_modem_irq;
  endproperty
  a_ring_edge: assert property (p_ring_edge) else $error("ring trailing edge missed");

  property p_modem_clr;
    rd_modem && delta_set == '0 |=> delta_q == '0 && !o_modem_irq;
  endproperty
  a_modem_clr: assert property (p_modem_clr) else $error("change bits survive read");

  property p_byte_a;
    wr_pad ##1 (i_rd_stb && i_addr == ulm_pkg::OFS_BYTE_A) |=> o_rd_data == $past(i_wr_data, 2);
  endproperty
  a_byte_a: assert property (p_byte_a) else $error("byte_a byte lost");

  c_fifo_overrun: cover property (fifo_overrun);
  c_hold_overrun: cover property (hold_overrun ##[1:4] rd_line);
  c_loop_irq: cover property (i_modem_ctl.loop ##1 o_modem_irq ##[1:4] rd_modem);

endmodule // ulm_line_modem_status

`default_nettype wire

// [verification/ulm_remote_line.sv]
// Remote serial device model: hands complete characters to the status block
`timescale 1ns/10ps
`default_nettype none

module ulm_remote_line (
  // Clock
  input wire logic i_clk,
  // Received characters
  output logic o_rx_valid,
  output ulm_pkg::ulm_rx_char_type o_rx_char
);
  // ==========================================================================
  // Character delivery
  // ==========================================================================
  initial
  begin
    o_rx_valid = 1'b0;
    o_rx_char = '0;
  end

  // Gap makes a slow sender; zero gap sends promptly
  task automatic send(input logic [7:0] data, input logic par_en, input logic par,
                      input logic stop, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_rx_valid <= 1'b1;
    o_rx_char <= '{data, par_en, par, stop, 1'b0};
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    // Stale character would hide a sampling slip
    o_rx_char <= ~o_rx_char;
  endtask
endmodule // ulm_remote_line

`default_nettype wire

// [verification/test_ulm_line_modem_status.sv]
// Testbench of the line and modem status block
`timescale 1ns/10ps
`default_nettype none

module test_ulm_line_modem_status;
  // ==========================================================================
  // Signals
  // ==========================================================================
  localparam int DEPTH = 4;
  localparam logic [7:0] LINE_M [4] = '{8'h20, 8'h10, 8'h40, 8'h80};
  localparam logic [7:0] RISE_M [4] = '{8'h02, 8'h01, 8'h00, 8'h08};
  localparam logic [7:0] FALL_M [4] = '{8'h02, 8'h01, 8'h04, 8'h08};
  logic i_clk;
  logic i_srst;
  logic [ulm_pkg::ADDR_W-1:0] i_addr;
  logic [ulm_pkg::DATA_W-1:0] i_wr_data;
  logic i_wr_stb;
  logic i_rd_stb;
  logic [ulm_pkg::DATA_W-1:0] o_rd_data;
  logic rx_valid;
  ulm_pkg::ulm_rx_char_type rx_char;
  logic o_rx_resync;
  logic i_fifo_mode;
  logic i_even_parity;
  ulm_pkg::ulm_modem_ctl_type i_modem_ctl;
  logic o_data_ready;
  logic o_modem_irq;
  logic [7:0] exp;
  int num_errors;
  int n_compared;
  int cycles;

  ulm_remote_line i_remote (
    .i_clk(i_clk),
    .o_rx_valid(rx_valid),
    .o_rx_char(rx_char)
  );

  ulm_line_modem_status #(.FIFO_DEPTH(DEPTH)) i_dut (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_addr(i_addr),
    .i_wr_data(i_wr_data),
    .i_wr_stb(i_wr_stb),
    .i_rd_stb(i_rd_stb),
    .o_rd_data(o_rd_data),
    .i_rx_valid(rx_valid),
    .i_rx_char(rx_char),
    .o_rx_resync(o_rx_resync),
    .i_fifo_mode(i_fifo_mode),
    .i_even_parity(i_even_parity),
    .i_modem_ctl(i_modem_ctl),
    .o_data_ready(o_data_ready),
    .o_modem_irq(o_modem_irq)
  );

  // ==========================================================================
  // Clock, timeout and tasks
  // ==========================================================================
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // About 165 cycles expected; generous ceiling
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      num_errors++;
      results();
    end
  end

  task automatic results();
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic chk_bit(input string name, input logic e, input logic g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", name, e, g);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr_stb <= 1'b1;
    @(posedge i_clk);
    i_wr_stb <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e, input string name);
    @(posedge i_clk);
    i_addr <= a;
    i_rd_stb <= 1'b1;
    @(posedge i_clk);
    i_rd_stb <= 1'b0;
    #1;
    chk_byte(name, e, o_rd_data);
  endtask

  task automatic snd(input logic [7:0] d, input logic pen, input logic p, input logic s);
    i_remote.send(d, pen, p, s, 0);
    #1;
  endtask

  // ==========================================================================
  // Tests
  // ==========================================================================
  initial
  begin
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    i_srst = 1'b1;
    i_addr = 3'h0;
    i_wr_data = 8'h00;
    i_wr_stb = 1'b0;
    i_rd_stb = 1'b0;
    i_fifo_mode = 1'b0;
    i_even_parity = 1'b0;
    i_modem_ctl = '0;
    wait_clk(2);
    i_srst <= 1'b0;
    rd_chk(3'h5, 8'h00, "line reset");
    rd_chk(3'h6, 8'h00, "modem reset");
    rd_chk(3'h7, 8'h00, "byte_a reset");
    rd_chk(3'h2, 8'h00, "unmapped");
    wr(3'h5, 8'hFF);
    wr(3'h7, 8'hA5);
    rd_chk(3'h5, 8'h00, "line read only");
    rd_chk(3'h7, 8'hA5, "byte_a");
    $display("test registers done");
    snd(8'h3C, 1'b0, 1'b0, 1'b0);
    chk_bit("resync", 1'b1, o_rx_resync);
    chk_bit("data ready", 1'b1, o_data_ready);
    rd_chk(3'h5, 8'h09, "framing");
    chk_bit("resync end", 1'b0, o_rx_resync);
    rd_chk(3'h5, 8'h01, "framing cleared");
    rd_chk(3'h0, 8'h3C, "rx data");
    chk_bit("data ready", 1'b0, o_data_ready);
    for (int p = 0; p < 2; p++)
    begin
      @(posedge i_clk);
      i_even_parity <= p[0];
      snd(8'h03, 1'b1, 1'b1, 1'b1);
      rd_chk(3'h5, p ? 8'h05 : 8'h01, "parity");
      rd_chk(3'h0, 8'h03, "parity data");
    end
    snd(8'hA1, 1'b0, 1'b0, 1'b1);
    snd(8'hA2, 1'b0, 1'b0, 1'b1);
    rd_chk(3'h5, 8'h03, "overrun");
    rd_chk(3'h0, 8'hA2, "overrun data");
    $display("test holding buffer done");
    @(posedge i_clk);
    i_fifo_mode <= 1'b1;
    snd(8'h11, 1'b0, 1'b0, 1'b1);
    snd(8'h22, 1'b0, 1'b0, 1'b0);
    wait_clk(2);
    rd_chk(3'h5, 8'h01, "error not at head");
    rd_chk(3'h0, 8'h11, "fifo data");
    wait_clk(2);
    rd_chk(3'h5, 8'h09, "error at head");
    rd_chk(3'h0, 8'h22, "fifo data");
    for (int i = 0; i <= DEPTH; i++)
      snd(8'h40 + i[7:0], 1'b0, 1'b0, 1'b1);
    rd_chk(3'h5, 8'h03, "fifo overrun");
    for (int i = 0; i < DEPTH; i++)
      rd_chk(3'h0, 8'h40 + i[7:0], "fifo drain");
    // Errored character into an empty FIFO becomes head at once
    snd(8'h5A, 1'b0, 1'b0, 1'b0);
    rd_chk(3'h5, 8'h09, "error at empty head");
    rd_chk(3'h0, 8'h5A, "empty head data");
    chk_bit("data ready", 1'b0, o_data_ready);
    $display("test fifo done");
    @(posedge i_clk);
    i_modem_ctl.loop <= 1'b1;
    wait_clk(2);
    rd_chk(3'h6, 8'h00, "modem idle");
    for (int i = 0; i < 4; i++)
    begin
      for (int v = 1; v >= 0; v--)
      begin
        @(posedge i_clk);
        i_modem_ctl[i] <= v[0];
        wait_clk(2);
        #1;
        exp = v ? RISE_M[i] : FALL_M[i];
        chk_bit("modem irq", |exp, o_modem_irq);
        rd_chk(3'h6, exp | (v ? LINE_M[i] : 8'h00), "modem");
        rd_chk(3'h6, v ? LINE_M[i] : 8'h00, "modem cleared");
        chk_bit("modem irq off", 1'b0, o_modem_irq);
      end
    end
    @(posedge i_clk);
    i_modem_ctl <= 8'h1F;
    wait_clk(2);
    rd_chk(3'h6, 8'hFB, "loop all");
    @(posedge i_clk);
    i_modem_ctl.loop <= 1'b0;
    wait_clk(2);
    rd_chk(3'h6, 8'h0F, "loop off");
    rd_chk(3'h6, 8'h00, "loop off cleared");
    $display("test modem done");
    results();
  end
endmodule // test_ulm_line_modem_status

`default_nettype wire
